// file: core/dcfs_regs.sv
// Our own choice: the Avalon-MM slave port.
`include "dcfs_cfg.svh"

module dcfs_regs
  import dcfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // avalon-mm slave, byte address
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // engine side
  input wire dcfs_evt_type evt,
  input wire logic precomp_pins_cfg,
  output logic remote_out_go,
  output logic remote_in_go,
  output logic correction_go,
  output logic new_cmd,
  output logic [7:0] drive_cmd,
  output logic op_abort,
  output logic precomp_active,
  output logic interlock_req,
  output logic ext_hdr_ecc_req,
  output logic [3:0] hdr_count,
  output dcfs_fmt_type fmt
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_ff; // two-stage release of the pin reset
  logic rst_n; // synchronised reset used by the rest of the block

  // release through two flops so all state leaves reset on one edge
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic rd_ack_ff; // second cycle of a read, data is ready
  logic [5:0] idx; // word index
  logic wr_ok; // write accepted this edge
  logic rd_ok; // read accepted this edge
  logic sel_status, sel_error, sel_hbc, sel_dc, sel_op, sel_fmt;
  logic wr_dc, wr_op, wr_fmt, wr_hbc; // accepted writes per register

  // reads take one wait cycle so read data leaves a flop
  assign waitrequest = !clk_en || (read && !rd_ack_ff);
  assign idx = address[7:2];
  assign wr_ok = write && !waitrequest && byteenable[0];
  assign rd_ok = read && !waitrequest;
  assign sel_status = (idx == `DCFS_IDX_STATUS);
  assign sel_error = (idx == `DCFS_IDX_ERROR);
  assign sel_hbc = (idx == `DCFS_IDX_HDR_COUNT);
  assign sel_dc = (idx == `DCFS_IDX_DRIVE_CMD);
  assign sel_op = (idx == `DCFS_IDX_OP_CMD);
  assign sel_fmt = (idx == `DCFS_IDX_FORMAT);
  assign wr_dc = wr_ok && sel_dc;
  assign wr_op = wr_ok && sel_op;
  assign wr_fmt = wr_ok && sel_fmt;
  assign wr_hbc = wr_ok && sel_hbc;

  // ****************************************************************
  // software-written registers
  // ****************************************************************
  logic [7:0] op_ff; // operation command bits
  logic [7:0] dc_ff; // drive command as last written
  logic [7:0] fmt_ff; // disk format configuration
  logic [3:0] hbc_ff; // header byte count / interlock strobe
  logic soft_rst; // soft reset bit held by software
  dcfs_hop_type hop; // header operation of the current command

  // writes land on the accepted edge only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_ff <= `DCFS_OP_RST;
      dc_ff <= `DCFS_DC_RST;
      fmt_ff <= `DCFS_FORMAT_RST;
      hbc_ff <= `DCFS_HBC_RST;
    end
    else if (clk_en)
    begin
      if (wr_op)
        op_ff <= writedata[7:0];
      if (wr_dc)
        dc_ff <= writedata[7:0];
      if (wr_fmt)
        fmt_ff <= writedata[7:0];
      if (wr_hbc)
        hbc_ff <= writedata[3:0];
    end
  end
  assign soft_rst = op_ff[`DCFS_OP_SOFT_RESET];
  assign hop = dcfs_hop_type'(dc_ff[`DCFS_DC_HOP_LSB +: 2]);
  assign drive_cmd = dc_ff;
  assign hdr_count = hbc_ff;

  // format fields straight from the stored byte
  // one driver for the whole struct; members named so a reorder cannot slip
  assign fmt = '{
    data_append: fmt_ff[7:6],
    hdr_append: fmt_ff[5:4],
    header_source_sel: fmt_ff[3],
    sector_kind: fmt_ff[2],
    mark_first: fmt_ff[1],
    encode_select: fmt_ff[0]
  };
  // without an internal header code the serial side must add its own
  assign ext_hdr_ecc_req = (fmt_ff[5:4] == `DCFS_APPEND_NONE);

  // ****************************************************************
  // command launches
  // ****************************************************************
  logic launch_ok; // start bits are ignored when the same write sets the soft reset bit
  logic go_out_ff, go_in_ff, go_corr_ff, new_cmd_ff, pre_ff;

  assign launch_ok = wr_op && !writedata[`DCFS_OP_SOFT_RESET];

  // start bits give one-cycle pulses to the dma and ecc engines
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      go_out_ff <= 1'b0;
      go_in_ff <= 1'b0;
      go_corr_ff <= 1'b0;
      new_cmd_ff <= 1'b0;
      pre_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      go_out_ff <= launch_ok && writedata[`DCFS_OP_REMOTE_OUT];
      go_in_ff <= launch_ok && writedata[`DCFS_OP_REMOTE_IN];
      go_corr_ff <= launch_ok && writedata[`DCFS_OP_CORRECT];
      new_cmd_ff <= wr_dc && !soft_rst;
      // precompensation needs the mark pins set up as precomp outputs
      pre_ff <= op_ff[`DCFS_OP_PRECOMP] && precomp_pins_cfg;
    end
  end
  assign remote_out_go = go_out_ff;
  assign remote_in_go = go_in_ff;
  assign correction_go = go_corr_ff;
  assign new_cmd = new_cmd_ff;
  assign precomp_active = pre_ff;

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic hf_ff, ncr_ff, hmd_ff, rbusy_ff, cact_ff, abort_ff;
  logic nxt_hf, nxt_ncr, nxt_hmd, nxt_rbusy, nxt_cact;
  logic [7:0] err_ff, nxt_err;
  logic hmd_set; // header-match-done set condition for this command
  logic rd_hdr_abort; // check error seen during a read header
  wire logic [7:0] status; // assembled status byte, one assign per bit

  // each set term is applied after its clear, so a set wins a tie; soft reset is applied last and beats every set
  assign hmd_set = (hop == DCFS_HOP_COMPARE) ? evt.hdr_match
                 : (hop == DCFS_HOP_READ) ? evt.hdr_field_seen
                 : evt.hdr_op_done;
  assign rd_hdr_abort = evt.hdr_check_err && (hop == DCFS_HOP_READ);

  always_comb
  begin
    nxt_hf = hf_ff;
    nxt_ncr = ncr_ff;
    nxt_hmd = hmd_ff;
    nxt_rbusy = rbusy_ff;
    nxt_cact = cact_ff;
    nxt_err = err_ff;
    // clears from commands and engine completions
    if (wr_dc)
    begin
      nxt_hf = 1'b0;
      nxt_ncr = 1'b0;
      nxt_err = 8'h00;
    end
    if (evt.sector_found)
      nxt_hf = 1'b0;
    if (evt.data_op_done)
      nxt_hmd = 1'b0;
    if (evt.remote_last_xfer)
      nxt_rbusy = 1'b0;
    if (evt.corr_done)
      nxt_cact = 1'b0;
    // sets; a header check error raises the fault flag
    if (evt.hdr_check_err)
      nxt_hf = 1'b1;
    if (evt.cmd_accept_ready)
      nxt_ncr = 1'b1;
    if (hmd_set)
      nxt_hmd = 1'b1;
    // a remote transfer in either direction occupies the remote channel
    if (go_out_ff || go_in_ff)
      nxt_rbusy = 1'b1;
    if (go_corr_ff)
      nxt_cact = 1'b1;
    // a read-header abort reports only through the fault flag
    if (!rd_hdr_abort)
      nxt_err = nxt_err | evt.err_set;
    // soft reset holds everything clear
    if (soft_rst)
    begin
      nxt_hf = 1'b0;
      nxt_ncr = 1'b0;
      nxt_hmd = 1'b0;
      nxt_rbusy = 1'b0;
      nxt_cact = 1'b0;
      nxt_err = 8'h00;
    end
  end

  // flag storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hf_ff <= 1'b0;
      ncr_ff <= 1'b0;
      hmd_ff <= 1'b0;
      rbusy_ff <= 1'b0;
      cact_ff <= 1'b0;
      err_ff <= 8'h00;
      abort_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      hf_ff <= nxt_hf;
      ncr_ff <= nxt_ncr;
      hmd_ff <= nxt_hmd;
      rbusy_ff <= nxt_rbusy;
      cact_ff <= nxt_cact;
      err_ff <= nxt_err;
      abort_ff <= rd_hdr_abort && !soft_rst;
    end
  end
  assign op_abort = abort_ff;

  // bit order is fixed by software's view of the register
  assign status[`DCFS_ST_HF] = hf_ff;
  assign status[`DCFS_ST_NCR] = ncr_ff;
  assign status[`DCFS_ST_HMD] = hmd_ff;
  assign status[`DCFS_ST_LRQ] = evt.local_dma_request && !soft_rst;
  assign status[`DCFS_ST_RBUSY] = rbusy_ff;
  assign status[`DCFS_ST_LBUSY] = evt.local_busy && !soft_rst;
  assign status[`DCFS_ST_CACT] = cact_ff;
  assign status[`DCFS_ST_ERR] = |err_ff;

  // ****************************************************************
  // interlock window
  // ****************************************************************
  dcfs_il_type il_ff, nxt_il;
  logic hmd_rise; // header-match-done goes high at this edge

  assign hmd_rise = nxt_hmd && !hmd_ff;

  // window opens on the match flag, the count write closes it
  always_comb
  begin
    nxt_il = il_ff;
    case (il_ff)
      DCFS_IL_IDLE:
        if (hmd_rise && op_ff[`DCFS_OP_INTERLOCK] && !soft_rst)
          nxt_il = DCFS_IL_OPEN;
      DCFS_IL_OPEN:
        if (wr_hbc || soft_rst)
          nxt_il = DCFS_IL_IDLE;
      default:
        nxt_il = DCFS_IL_IDLE;
    endcase
  end

  // window state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      il_ff <= DCFS_IL_IDLE;
    else if (clk_en)
      il_ff <= nxt_il;
  end
  assign interlock_req = (il_ff == DCFS_IL_OPEN);

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] rd_mux; // selected register byte
  logic [31:0] rdata_ff;

  // write-only and unmapped registers read as zero; count shows 3 bits
  assign rd_mux = sel_status ? status
                : sel_error ? err_ff
                : sel_hbc ? {5'h00, hbc_ff[2:0]}
                : 8'h00;

  // data is captured in the wait cycle and held for the answer edge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_ack_ff <= read && !rd_ack_ff;
      if (read && !rd_ack_ff)
        rdata_ff <= {24'h00_0000, rd_mux};
    end
  end
  assign readdata = rdata_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sro_write_s;
    clk_en && wr_op && !writedata[`DCFS_OP_SOFT_RESET] && writedata[`DCFS_OP_REMOTE_OUT];
  endsequence
  sequence busy_seen_s;
    remote_out_go ##1 (rbusy_ff || !clk_en);
  endsequence

  remote_launch_a: assert property (sro_write_s |=> busy_seen_s)
    else $error("remote output start did not launch");
  precomp_gate_a: assert property (clk_en && !(op_ff[5] && precomp_pins_cfg)
    |=> !precomp_active)
    else $error("precompensation active without precomp pins");
  corr_launch_a: assert property (clk_en && wr_op && !writedata[0] && writedata[6]
    |=> correction_go ##1 (cact_ff || !clk_en))
    else $error("correction cycle not launched");
  interlock_open_a: assert property (clk_en && hmd_rise && op_ff[7] && !soft_rst
    && !interlock_req |=> interlock_req)
    else $error("interlock window did not open");
  interlock_close_a: assert property (clk_en && interlock_req && wr_hbc |=> !interlock_req)
    else $error("header count write did not close window");
  encode_sel_a: assert property (clk_en && wr_fmt |=> fmt.encode_select == $past(writedata[0]))
    else $error("encode select not taken from format write");
  fault_set_a: assert property (clk_en && evt.hdr_check_err && !soft_rst |=> hf_ff)
    else $error("header fault not set by check error");
  fault_cmd_clr_a: assert property (clk_en && wr_dc && !evt.hdr_check_err && !soft_rst
    && !evt.cmd_accept_ready |=> !hf_ff && !ncr_ff)
    else $error("new command did not clear fault or ready");
  soft_clear_a: assert property (clk_en && soft_rst |=> (status & 8'hF7 & ~8'h20) == 8'h00)
    else $error("soft reset left a status flag set");
  abort_noerr_a: assert property (clk_en && rd_hdr_abort && !soft_rst && !wr_dc
    |=> op_abort && err_ff == $past(err_ff))
    else $error("read header abort touched error register");
  status_read_a: assert property (clk_en && read && !rd_ack_ff && sel_status
    |=> readdata[7] == $past(|err_ff) && readdata[3] == $past(status[3]))
    else $error("status read lost error or request bit");
  busy_clear_a: assert property (clk_en && evt.remote_last_xfer && !go_out_ff && !go_in_ff
    |=> !rbusy_ff)
    else $error("remote busy not cleared on last transfer");

endmodule : dcfs_regs

// file: core/dcfs_cfg.svh
`ifndef DCFS_CFG_SVH
`define DCFS_CFG_SVH
// register indices; byte address is four times the index
`define DCFS_IDX_STATUS 6'h00
`define DCFS_IDX_ERROR 6'h01
`define DCFS_IDX_HDR_COUNT 6'h0F
`define DCFS_IDX_DRIVE_CMD 6'h10
`define DCFS_IDX_OP_CMD 6'h11
`define DCFS_IDX_FORMAT 6'h35
// status bit positions
`define DCFS_ST_HF 0
`define DCFS_ST_NCR 1
`define DCFS_ST_HMD 2
`define DCFS_ST_LRQ 3
`define DCFS_ST_RBUSY 4
`define DCFS_ST_LBUSY 5
`define DCFS_ST_CACT 6
`define DCFS_ST_ERR 7
// operation command bit positions
`define DCFS_OP_SOFT_RESET 0
`define DCFS_OP_INT_EN 1
`define DCFS_OP_HDR_INT_EN 2
`define DCFS_OP_REMOTE_IN 3
`define DCFS_OP_REMOTE_OUT 4
`define DCFS_OP_PRECOMP 5
`define DCFS_OP_CORRECT 6
`define DCFS_OP_INTERLOCK 7
// drive command header-operation field
`define DCFS_DC_HOP_LSB 4
// append codes
`define DCFS_APPEND_NONE 2'h0
// reset values
`define DCFS_FORMAT_RST 8'h00
`define DCFS_OP_RST 8'h00
`define DCFS_DC_RST 8'h00
`define DCFS_HBC_RST 4'h2
// largest external check code wrapped around a sector, in bytes
`define DCFS_EXT_ECC_MAX_BYTES 31
`endif

// file: core/dcfs_pkg.sv
package dcfs_pkg;
  // header operation codes held in the drive command
  typedef enum logic [1:0] {
    DCFS_HOP_IGNORE = 2'h0,
    DCFS_HOP_COMPARE = 2'h1,
    DCFS_HOP_WRITE = 2'h2,
    DCFS_HOP_READ = 2'h3
  } dcfs_hop_type;

  // interlock window state
  typedef enum logic [0:0] {
    DCFS_IL_IDLE = 1'b0,
    DCFS_IL_OPEN = 1'b1
  } dcfs_il_type;

  // format configuration as seen by the serial side
  typedef struct packed {
    logic [1:0] data_append;
    logic [1:0] hdr_append;
    logic header_source_sel;
    logic sector_kind;
    logic mark_first;
    logic encode_select;
  } dcfs_fmt_type;

  // events and levels from the disk, fifo, dma and ecc engines
  typedef struct packed {
    logic hdr_check_err;
    logic sector_found;
    logic hdr_match;
    logic hdr_field_seen;
    logic hdr_op_done;
    logic data_op_done;
    logic cmd_accept_ready;
    logic remote_last_xfer;
    logic local_busy;
    logic local_dma_request;
    logic corr_done;
    logic [7:0] err_set;
  } dcfs_evt_type;
endpackage : dcfs_pkg

// file: sim/dcfs_host_model.sv
// ****************************************
// host bus master model
// ****************************************
module dcfs_host_model (
  input wire logic ref_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle from time zero so nothing is requested during reset
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
  end

  // write cycle: hold everything until waitrequest is seen low at an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= 4'hF;
    write <= 1'b1;
    do @(posedge ref_clk); while (waitrequest);
    write <= 1'b0;
  endtask : wr

  // read cycle: data is taken at the same edge that ends the wait
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    byteenable <= 4'hF;
    read <= 1'b1;
    do @(posedge ref_clk); while (waitrequest);
    d = readdata;
    read <= 1'b0;
  endtask : rd

  // end of an interlock update: the count doubles as the strobe
  task automatic hdr_strobe(input logic [3:0] n);
    logic [3:0] c;
    c = n;
    // out-of-range counts are never sent; the device does not police them
    if (c < 4'h2 || c > 4'h6)
      c = 4'h2;
    wr(8'h3C, {4'h0, c});
  endtask : hdr_strobe
endmodule : dcfs_host_model

// file: sim/tb_top.sv
module tb_top
  import dcfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals and event codes
  // ****************************************
  logic ref_clk, reset_n, clk_en, read, write, waitrequest, precomp_pins_cfg;
  logic [7:0] address, drive_cmd;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, hdr_count;
  logic remote_out_go, remote_in_go, correction_go, new_cmd, op_abort;
  logic precomp_active, interlock_req, ext_hdr_ecc_req;
  dcfs_evt_type evt;
  dcfs_fmt_type fmt;
  logic [18:0] base; // held levels: local busy and local request
  int mismatches, n_tests;
  // one-hot event patterns in struct order
  localparam logic [18:0] E_CHK = 19'h40000, E_FOUND = 19'h20000, E_MATCH = 19'h10000;
  localparam logic [18:0] E_FIELD = 19'h08000, E_HOPD = 19'h04000, E_DATD = 19'h02000;
  localparam logic [18:0] E_RDY = 19'h01000, E_LAST = 19'h00800, E_CORR = 19'h00100;

  dcfs_host_model host (.ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));

  dcfs_regs uut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .evt(evt),
    .precomp_pins_cfg(precomp_pins_cfg), .remote_out_go(remote_out_go),
    .remote_in_go(remote_in_go), .correction_go(correction_go), .new_cmd(new_cmd),
    .drive_cmd(drive_cmd), .op_abort(op_abort), .precomp_active(precomp_active),
    .interlock_req(interlock_req), .ext_hdr_ecc_req(ext_hdr_ecc_req),
    .hdr_count(hdr_count), .fmt(fmt));

  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk(n, e, d);
  endtask : rd_chk

  // events are pulses of one cycle; returns just after the edge that took them
  task automatic pulse(input logic [18:0] p);
    @(posedge ref_clk);
    evt <= dcfs_evt_type'(p | base);
    @(posedge ref_clk);
    evt <= dcfs_evt_type'(base);
    #1;
  endtask : pulse

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk("status", 8'h00, 32'h00000000);
    rd_chk("hdr count", 8'h3C, 32'h00000002);
    rd_chk("unmapped", 8'h08, 32'h00000000);
    rd_chk("format readback", 8'hD4, 32'h00000000);
    chk("fmt", 32'h00000000, fmt);
    $display("test reset done");
  endtask : t_reset

  // every code of both append fields and both values of each low bit
  task automatic t_format;
    logic [7:0] tbl [4];
    tbl = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
    foreach (tbl[i])
    begin
      host.wr(8'hD4, tbl[i]);
      #1;
      chk("fmt", tbl[i], fmt);
      chk("ext ecc", tbl[i][5:4] == 2'h0, ext_hdr_ecc_req);
    end
    $display("test format done");
  endtask : t_format

  task automatic t_launch;
    host.wr(8'h44, 8'h58);
    #1;
    chk("remote out go", 32'h00000001, remote_out_go);
    chk("remote in go", 32'h00000001, remote_in_go);
    chk("correction go", 32'h00000001, correction_go);
    @(posedge ref_clk);
    #1;
    chk("remote out go", 32'h00000000, remote_out_go);
    rd_chk("status", 8'h00, 32'h00000050);
    pulse(E_LAST);
    rd_chk("status", 8'h00, 32'h00000040);
    pulse(E_CORR);
    rd_chk("status", 8'h00, 32'h00000000);
    host.wr(8'h44, 8'h20);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("precomp", 32'h00000000, precomp_active);
    @(posedge ref_clk);
    precomp_pins_cfg <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("precomp", 32'h00000001, precomp_active);
    host.wr(8'h44, 8'h51);
    #1;
    chk("go in soft reset", 32'h00000000, remote_out_go);
    host.wr(8'h44, 8'h00);
    $display("test launch done");
  endtask : t_launch

  // each header operation with the event that completes its header
  task automatic t_match;
    logic [18:0] ev [4];
    ev = '{E_HOPD, E_MATCH, E_HOPD, E_FIELD};
    for (int h = 0; h < 4; h++)
    begin
      host.wr(8'h40, {2'h1, h[1:0], 4'h0});
      #1;
      chk("new cmd", 32'h00000001, new_cmd);
      if (h == 1)
      begin
        pulse(E_FIELD);
        rd_chk("status", 8'h00, 32'h00000000);
      end
      pulse(ev[h]);
      rd_chk("status", 8'h00, 32'h00000004);
      pulse(E_DATD);
      rd_chk("status", 8'h00, 32'h00000000);
    end
    pulse(E_RDY);
    rd_chk("status", 8'h00, 32'h00000002);
    host.wr(8'h40, 8'h40);
    rd_chk("status", 8'h00, 32'h00000000);
    $display("test match done");
  endtask : t_match

  task automatic t_fault;
    host.wr(8'h40, 8'h50);
    pulse(E_CHK);
    rd_chk("status", 8'h00, 32'h00000001);
    pulse(E_FOUND);
    rd_chk("status", 8'h00, 32'h00000000);
    pulse(E_CHK);
    host.wr(8'h40, 8'h50);
    rd_chk("status", 8'h00, 32'h00000000);
    host.wr(8'h40, 8'h70);
    pulse(E_CHK | 19'h00001);
    chk("abort", 32'h00000001, op_abort);
    rd_chk("status", 8'h00, 32'h00000001);
    rd_chk("error", 8'h04, 32'h00000000);
    host.wr(8'h40, 8'h50);
    $display("test fault done");
  endtask : t_fault

  task automatic t_errs;
    pulse(19'h00080);
    rd_chk("error", 8'h04, 32'h00000080);
    rd_chk("status", 8'h00, 32'h00000080);
    base = 19'h00600;
    pulse(19'h00000);
    rd_chk("status", 8'h00, 32'h000000A8);
    host.wr(8'h44, 8'h01);
    rd_chk("status", 8'h00, 32'h00000000);
    rd_chk("error", 8'h04, 32'h00000000);
    host.wr(8'h44, 8'h00);
    rd_chk("status", 8'h00, 32'h00000028);
    base = 19'h00000;
    pulse(19'h00000);
    rd_chk("status", 8'h00, 32'h00000000);
    $display("test errors done");
  endtask : t_errs

  task automatic t_interlock;
    host.wr(8'h44, 8'h80);
    host.wr(8'h40, 8'h40);
    #1;
    chk("drive cmd", 32'h00000040, drive_cmd);
    pulse(E_HOPD);
    @(posedge ref_clk);
    #1;
    chk("interlock", 32'h00000001, interlock_req);
    host.hdr_strobe(4'h5);
    @(posedge ref_clk);
    #1;
    chk("interlock", 32'h00000000, interlock_req);
    chk("hdr count", 32'h00000005, hdr_count);
    rd_chk("hdr count", 8'h3C, 32'h00000005);
    pulse(E_DATD);
    host.wr(8'h44, 8'h00);
    $display("test interlock done");
  endtask : t_interlock

  // pin reset in mid-run clears flags and returns the count to 2; a frozen clock enable drops events
  task automatic t_pin_reset;
    pulse(E_RDY | 19'h00001);
    rd_chk("status", 8'h00, 32'h00000082);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    // internal copy releases two edges later; keep the bus quiet till then
    repeat (4) @(posedge ref_clk);
    rd_chk("status", 8'h00, 32'h00000000);
    rd_chk("error", 8'h04, 32'h00000000);
    rd_chk("hdr count", 8'h3C, 32'h00000002);
    clk_en <= 1'b0;
    pulse(E_RDY);
    chk("stall wait", 32'h00000001, waitrequest);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_chk("status", 8'h00, 32'h00000000);
    $display("test pin reset done");
  endtask : t_pin_reset

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    precomp_pins_cfg = 1'b0;
    base = 19'h00000;
    evt = dcfs_evt_type'(19'h00000);
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // internal reset copy needs two edges; first request from the third
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_format();
    t_launch();
    t_match();
    t_fault();
    t_errs();
    t_interlock();
    t_pin_reset();
    close_out();
  end

  // the tests take well under a thousand cycles; this margin only cuts a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : tb_top
